// >>> logic/fnt_regs.svh
// Purpose: register codes, field positions and reset values of the frame timing block
// Assumes: command codes are 8 bits, bit 7 set marks a write
// Notes: definitions only
`ifndef FNT_REGS_SVH
`define FNT_REGS_SVH
`define FNT_CMD_FRAME_RD 8'h0F
`define FNT_CMD_CUTOFF_RD 8'h11
`define FNT_CMD_CUTOFF_WR 8'h91
`define FNT_CMD_HUBA_RD 8'h12
`define FNT_CMD_HUBA_WR 8'h92
`define FNT_CUTOFF_RST 11'h628
`define FNT_FRAME_LEN_RST 14'h2EDF
`define FNT_HUBA_SETTLE_RST 8'h18
`define FNT_HUBA_PORTS_RST 8'h02
`define FNT_HUBA_SETTLE_HI 31
`define FNT_HUBA_SETTLE_LO 24
`define FNT_HUBA_NOGUARD 12
`define FNT_HUBA_OVLMODE 11
`define FNT_HUBA_COMPOUND 10
`define FNT_HUBA_NOSWITCH 9
`define FNT_HUBA_SWMODE 8
`define FNT_HUBA_PORTS_HI 7
`define FNT_PORTS_MIN 8'h01
`define FNT_PORTS_MAX 8'h02
`endif

// >>> logic/fnt_pkg.sv
// Purpose: shared types of the frame timing block
// Assumes: nothing
// Notes: constants live in fnt_regs.svh
package fnt_pkg;
  typedef logic [15:0] fnt_count_t;
  typedef enum logic [1:0] {
    FNT_IDLE = 2'b00,
    FNT_RUN = 2'b01
  } fnt_run_e;
endpackage

// >>> logic/fnt_bit_counter.sv
// Purpose: bit-times-left down counter with reload at frame end
// Assumes: bit_tick is a one-cycle pulse per bit time
// Notes: reload pulse is combinational, high in the cycle whose edge reloads the counter
`timescale 1ns/1ns
module fnt_bit_counter #(
  parameter int WIDTH = 14
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic start,
  input wire logic [WIDTH-1:0] frame_length_value,
  output logic [WIDTH-1:0] bit_times_left,
  output logic reload
);
  // reload pulse on the reload edge
  assign reload = bit_tick && !start && (bit_times_left == '0);

  always_ff @(posedge clk) begin
    if (rst) begin
      bit_times_left <= '0;
    end else begin
      if (start) begin
        bit_times_left <= frame_length_value;
      end else if (bit_tick) begin
        if (bit_times_left == '0) begin
          bit_times_left <= frame_length_value;
        end else begin
          bit_times_left <= bit_times_left - 1'b1;
        end
      end
    end
  end
endmodule // fnt_bit_counter

// >>> logic/fnt_frame_timing.sv
// Purpose: frame number, slow transfer cutoff and first hub descriptor
// Assumes: command port synchronous to clk; 20 MHz clock, bit ticks from outside
// Notes: reads answer one cycle after the command strobe
// Functional notes
// - Frame count rises on each bit-times-left reload.
// - Frame count wraps from FFFF to zero.
// - Entering running state increments frame count once.
// - Every frame count advance sets the frame-start flag.
// - Code 0F reads frame count, upper sixteen bits zero.
// - Codes 11 and 91 read and write the cutoff register.
// - Low-speed start only when bit-times-left is at least the cutoff.
// - Cutoff guards an 8-byte low-speed packet; software keeps it.
// - Hub registers are accessed as whole 32-bit words.
// - Hub descriptor writes accepted in every state.
// - First hub descriptor field layout, compound flag reads zero.
// - Bit-times-left decrements per bit, reloads at zero.
// - Port count reports one or two ports.
`timescale 1ns/1ns
`include "fnt_regs.svh"
module fnt_frame_timing #(
  parameter int FL_WIDTH = 14,
  parameter int CUT_WIDTH = 11
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic bit_tick,
  input wire logic run_request,
  input wire logic [FL_WIDTH-1:0] frame_length_value,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic ls_request,
  input wire logic frame_start_clear,
  output logic [31:0] rd_data,
  output logic rd_valid,
  output logic running_state,
  output logic frame_start_flag,
  output logic ls_start,
  output logic [FL_WIDTH-1:0] bit_times_left
);
  fnt_pkg::fnt_run_e run_r;
  fnt_pkg::fnt_run_e run_nxt;
  fnt_pkg::fnt_count_t frame_count_r;
  logic [CUT_WIDTH-1:0] cutoff_r;
  logic [7:0] settle_r;
  logic noguard_r;
  logic ovlmode_r;
  logic noswitch_r;
  logic swmode_r;
  logic [7:0] ports_r;
  logic reload;
  logic enter_run;
  logic advance;
  logic [31:0] huba_word;
  fnt_pkg::fnt_count_t frame_count_nxt;
  logic [7:0] ports_nxt;
  logic [FL_WIDTH-1:0] cutoff_wide;
  logic ls_room;
  logic wr_cutoff;
  logic wr_huba;

  // Next run state follows the request level
  always_comb begin
    case (run_r)
      fnt_pkg::FNT_IDLE: run_nxt = run_request ? fnt_pkg::FNT_RUN : fnt_pkg::FNT_IDLE;
      fnt_pkg::FNT_RUN: run_nxt = run_request ? fnt_pkg::FNT_RUN : fnt_pkg::FNT_IDLE;
      default: run_nxt = fnt_pkg::FNT_IDLE;
    endcase
  end

  assign enter_run = (run_r == fnt_pkg::FNT_IDLE) && (run_nxt == fnt_pkg::FNT_RUN);
  assign advance = reload || enter_run;

  // Write strobes decoded once for the register processes
  assign wr_cutoff = cmd_valid && (cmd_code == `FNT_CMD_CUTOFF_WR);
  assign wr_huba = cmd_valid && (cmd_code == `FNT_CMD_HUBA_WR);

  // wrap to zero after the top value
  always_comb begin
    if (frame_count_r == '1) begin
      frame_count_nxt = '0;
    end else begin
      frame_count_nxt = frame_count_r + 16'h0001;
    end
  end

  // port count clamped to the supported range
  always_comb begin
    ports_nxt = cmd_wdata[`FNT_HUBA_PORTS_HI:0];
    if (ports_nxt < `FNT_PORTS_MIN) begin
      ports_nxt = `FNT_PORTS_MIN;
    end else if (ports_nxt > `FNT_PORTS_MAX) begin
      ports_nxt = `FNT_PORTS_MAX;
    end
  end

  // cutoff widened to the counter width for the compare
  assign cutoff_wide = {{(FL_WIDTH-CUT_WIDTH){1'b0}}, cutoff_r};
  assign ls_room = (bit_times_left >= cutoff_wide);

  fnt_bit_counter #(.WIDTH(FL_WIDTH)) u_bits (
    .clk(clk),
    .rst(rst),
    .bit_tick(bit_tick && (run_r == fnt_pkg::FNT_RUN)),
    .start(enter_run),
    .frame_length_value(frame_length_value),
    .bit_times_left(bit_times_left),
    .reload(reload)
  );

  // running state exported to gate state-register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      run_r <= fnt_pkg::FNT_IDLE;
      running_state <= 1'b0;
    end else begin
      case (run_r)
        fnt_pkg::FNT_IDLE: run_r <= run_nxt;
        fnt_pkg::FNT_RUN: run_r <= run_nxt;
        default: run_r <= fnt_pkg::FNT_IDLE;
      endcase
      running_state <= run_request;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_count_r <= '0;
    end else if (advance) begin
      frame_count_r <= frame_count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      frame_start_flag <= 1'b0;
    end else if (advance) begin
      frame_start_flag <= 1'b1;
    end else if (frame_start_clear) begin
      frame_start_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cutoff_r <= `FNT_CUTOFF_RST;
    end else if (wr_cutoff) begin
      cutoff_r <= cmd_wdata[CUT_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      settle_r <= `FNT_HUBA_SETTLE_RST;
      noguard_r <= 1'b0;
      ovlmode_r <= 1'b1;
      noswitch_r <= 1'b0;
      swmode_r <= 1'b1;
      ports_r <= `FNT_HUBA_PORTS_RST;
    end else if (wr_huba) begin
      settle_r <= cmd_wdata[`FNT_HUBA_SETTLE_HI:`FNT_HUBA_SETTLE_LO];
      noguard_r <= cmd_wdata[`FNT_HUBA_NOGUARD];
      ovlmode_r <= cmd_wdata[`FNT_HUBA_OVLMODE];
      noswitch_r <= cmd_wdata[`FNT_HUBA_NOSWITCH];
      swmode_r <= cmd_wdata[`FNT_HUBA_SWMODE];
      ports_r <= ports_nxt;
    end
  end

  always_comb begin
    huba_word = '0;
    huba_word[`FNT_HUBA_SETTLE_HI:`FNT_HUBA_SETTLE_LO] = settle_r;
    huba_word[`FNT_HUBA_NOGUARD] = noguard_r;
    huba_word[`FNT_HUBA_OVLMODE] = ovlmode_r;
    huba_word[`FNT_HUBA_COMPOUND] = 1'b0;
    huba_word[`FNT_HUBA_NOSWITCH] = noswitch_r;
    huba_word[`FNT_HUBA_SWMODE] = swmode_r;
    huba_word[`FNT_HUBA_PORTS_HI:0] = ports_r;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (cmd_valid) begin
        case (cmd_code)
          `FNT_CMD_FRAME_RD: begin
            rd_data <= {16'h0000, frame_count_r};
            rd_valid <= 1'b1;
          end
          `FNT_CMD_CUTOFF_RD: begin
            rd_data <= {{(32-CUT_WIDTH){1'b0}}, cutoff_r};
            rd_valid <= 1'b1;
          end
          `FNT_CMD_HUBA_RD: begin
            rd_data <= huba_word;
            rd_valid <= 1'b1;
          end
          default: rd_data <= rd_data;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ls_start <= 1'b0;
    end else begin
      ls_start <= ls_request && (run_r == fnt_pkg::FNT_RUN) && ls_room;
    end
  end
endmodule // fnt_frame_timing

// >>> verif/fnt_checker.sv
// Purpose: port checks of fnt_frame_timing
// Assumes: one clock, sync reset
// Notes: bound below
`timescale 1ns/1ns
module fnt_chk #(parameter int FL_WIDTH = 14) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  input wire logic run_request,
  input wire logic running_state,
  input wire logic bit_tick,
  input wire logic [FL_WIDTH-1:0] bit_times_left,
  input wire logic [FL_WIDTH-1:0] frame_length_value,
  input wire logic frame_start_flag,
  input wire logic frame_start_clear,
  input wire logic ls_start,
  input wire logic ls_request
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rq, tk;
  assign rq = cmd_valid && cmd_code inside {8'h0F, 8'h11, 8'h12};
  assign tk = running_state && run_request && bit_tick;
  a_read_answer: assert property (rq |=> rd_valid)
    else $error("no answer");
  a_no_stray: assert property (!rq |=> !rd_valid)
    else $error("stray answer");
  a_frame_hi: assert property (rq && cmd_code == 8'h0F |=> rd_data[31:16] == 16'h0)
    else $error("frame high bits");
  a_hub_fields: assert property (rq && cmd_code == 8'h12 |=> !rd_data[10] && rd_data[7:0] inside {8'h01, 8'h02})
    else $error("hub fields");
  a_bit_dec: assert property (tk && bit_times_left != 0 |=> bit_times_left == $past(bit_times_left) - 1'b1)
    else $error("no decrement");
  a_frame_reload: assert property (tk && bit_times_left == 0 |=> bit_times_left == $past(frame_length_value) && frame_start_flag)
    else $error("bad reload");
  a_run_entry: assert property (run_request && !running_state |=> running_state && frame_start_flag)
    else $error("bad entry");
  a_flag_hold: assert property (frame_start_flag && !frame_start_clear |=> frame_start_flag)
    else $error("flag lost");
  a_ls_gate: assert property (ls_start |-> $past(ls_request))
    else $error("stray start");
  c_reload: cover property (tk && bit_times_left == 0);
  c_entry: cover property ($rose(running_state));
  c_ls: cover property (ls_start);
endmodule // fnt_chk
bind fnt_frame_timing fnt_chk #(.FL_WIDTH(FL_WIDTH)) u_chk (.clk, .rst, .cmd_valid, .cmd_code,
  .rd_data, .rd_valid, .run_request, .running_state, .bit_tick, .bit_times_left,
  .frame_length_value, .frame_start_flag, .frame_start_clear, .ls_start, .ls_request);

// >>> verif/fnt_host_model.sv
// Purpose: host processor issuing command codes
// Assumes: one command per call
// Notes: released lines show inverted data
`timescale 1ns/1ns
module fnt_host_model (
  input wire logic clk,
  output logic cmd_valid = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [31:0] cmd_wdata = 32'h0,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid
);
  task automatic xfer(input logic [7:0] c, input logic [31:0] d, output logic [31:0] r);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_wdata = d;
    @(negedge clk);
    // Answer stands from the taking edge to the next one
    r = (rd_valid === 1'b1) ? rd_data : 'x;
    cmd_valid = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask
endmodule // fnt_host_model

// >>> verif/testbench.sv
// Purpose: self-checking bench of fnt_frame_timing
// Assumes: bench makes the bit ticks
// Notes: count wrap is too long for this run
`timescale 1ns/1ns
`define C(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bit_tick = 1'b0;
  logic run_request = 1'b0;
  logic ls_request = 1'b0;
  logic frame_start_clear = 1'b0;
  logic [13:0] frame_length_value = 14'h0005;
  logic cmd_valid, rd_valid, running_state, frame_start_flag, ls_start;
  logic [7:0] cmd_code;
  logic [31:0] cmd_wdata, rd_data, r, w;
  logic [13:0] bit_times_left, e;
  logic [15:0] fr = 16'h0000;
  int num_errors = 0;
  int compares = 0;
  int k, j, n;
  initial forever #25 clk = ~clk;
  fnt_host_model host (.clk, .cmd_valid, .cmd_code, .cmd_wdata, .rd_data, .rd_valid);
  fnt_frame_timing dut (.clk, .rst, .bit_tick, .run_request, .frame_length_value, .cmd_valid,
    .cmd_code, .cmd_wdata, .ls_request, .frame_start_clear, .rd_data, .rd_valid, .running_state,
    .frame_start_flag, .ls_start, .bit_times_left);
  function automatic logic [31:0] hub_exp(input logic [31:0] v);
    logic [7:0] p;
    p = (v[7:0] == 8'h00) ? 8'h01 : (v[7:0] > 8'h02) ? 8'h02 : v[7:0];
    return {v[31:24], 11'h000, v[12:11], 1'b0, v[9:8], p};
  endfunction
  task automatic tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #250000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    k = $urandom(32'hDC90);
    repeat (10) @(negedge clk);
    rst = 1'b0;
    host.xfer(8'h0F, 32'h0, r);
    `C("frame", 32'h0, r)
    host.xfer(8'h11, 32'h0, r);
    `C("cutoff", 32'h628, r)
    host.xfer(8'h12, 32'h0, r);
    `C("hub", 32'h18000902, r)
    for (k = 0; k < 6; k++) begin
      w = $urandom & 32'hFF001FFF;
      if (k < 3)
        w[7:0] = 8'(k);
      @(negedge clk);
      run_request = k[0];
      fr += 16'(k[0]);
      host.xfer(8'h92, w, r);
      host.xfer(8'h12, 32'h0, r);
      `C("hub", hub_exp(w), r)
      host.xfer(8'h91, w, r);
      host.xfer(8'h11, 32'h0, r);
      `C("cutoff", {21'h0, w[10:0]}, r)
    end
    for (k = 0; k < 3; k++) begin
      @(negedge clk);
      run_request = 1'b0;
      frame_length_value = 14'(2 + $urandom % 9);
      n = 5 + $urandom % 40;
      @(negedge clk);
      run_request = 1'b1;
      repeat (3) @(negedge clk);
      `C("run", 1'b1, running_state)
      frame_start_clear = 1'b1;
      @(negedge clk);
      frame_start_clear = 1'b0;
      bit_tick = 1'b1;
      repeat (n) @(negedge clk);
      bit_tick = 1'b0;
      fr += 16'(1 + n / (frame_length_value + 1));
      e = frame_length_value - 14'(n % (frame_length_value + 1));
      `C("left", e, bit_times_left)
      `C("flag", n > frame_length_value, frame_start_flag)
      host.xfer(8'h0F, 32'h0, r);
      `C("frame", {16'h0, fr}, r)
      for (j = 0; j < 3; j++) begin
        w = 32'(e) + 32'(j) - 32'h1;
        host.xfer(8'h91, w, r);
        @(negedge clk);
        ls_request = 1'b1;
        @(negedge clk);
        ls_request = 1'b0;
        `C("ls", e >= 14'(w[10:0]), ls_start)
      end
    end
    tally_and_finish;
  end
endmodule // testbench
